//--- logic/pss_pkg.sv
package pss_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets on the AXI4-Lite slave.
    // ------------------------------------------------------------------
    localparam logic [7:0] PSS_OFF_PORTG = 8'h00;
    localparam logic [7:0] PSS_OFF_INTCTL = 8'h04;
    localparam logic [7:0] PSS_OFF_CANBUS = 8'h08;
    localparam logic [7:0] PSS_OFF_PORTM_WAKEUP_ENABLE_REG = 8'h0C;
    localparam logic [7:0] PSS_OFF_STATUS = 8'h10;
    localparam logic [7:0] PSS_OFF_IRQ_STS = 8'h14;
    localparam logic [7:0] PSS_OFF_IRQ_MSK = 8'h18;
    localparam logic [7:0] PSS_OFF_LWKEN = 8'h1C;

    // ------------------------------------------------------------------
    // Field positions.
    // ------------------------------------------------------------------
    localparam int PSS_HALT_BIT = 7;
    localparam int PSS_IDLE_BIT = 6;
    localparam int PSS_PEND_BIT = 5;
    localparam int PSS_TEN_BIT = 4;
    localparam int PSS_GIE_BIT = 0;
    localparam int PSS_CANWK_BIT = 7;
    localparam int PSS_RXLO_BIT = 0;
    localparam int PSS_RXHI_BIT = 1;
    localparam int PSS_IDLE_TAP = 12;

    // ------------------------------------------------------------------
    // Reset values and cycle counts.
    // ------------------------------------------------------------------
    localparam logic [7:0] PSS_RST_BYTE = 8'h00;
    localparam logic [15:0] PSS_WAKE_LOAD = 16'h0100;
    localparam int PSS_OSC_DIV = 10;
    localparam logic [3:0] PSS_DIV_LAST = 4'(PSS_OSC_DIV - 1);

    // Power states.
    typedef enum logic [1:0] {
        PSS_RUN,
        PSS_IDLE,
        PSS_HALT,
        PSS_SETTLE
    } pss_state_t;

    // Events raised by the core toward the interrupt status register.
    typedef struct packed {
        logic wake_done;
        logic idle_exit;
        logic tick;
    } pss_evt_t;

endpackage

//--- logic/pss_divider.sv
`timescale 1ns/100ps
`default_nettype none
// Divides the oscillator rate down to the instruction cycle strobe.
module pss_divider
    import pss_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic run_i,
    output logic tick_o
);
    // Position inside one instruction cycle.
    logic [3:0] phase;

    // ------------------------------------------------------------------
    // Counter: one strobe in every ten oscillator clocks.
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            phase <= 4'h0;
            tick_o <= 1'b0;
        end else if (!run_i) begin
            // Halted oscillator: no strobes at all.
            phase <= 4'h0;
            tick_o <= 1'b0;
        end else if (phase == PSS_DIV_LAST) begin
            phase <= 4'h0;
            tick_o <= 1'b1;
        end else begin
            phase <= phase + 4'h1;
            tick_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- logic/pss_idle_timer.sv
`timescale 1ns/100ps
`default_nettype none
// Free running idle timer with a settle load and the bit-12 toggle event.
module pss_idle_timer
    import pss_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic tick_i,
    input wire logic load_i,
    output logic [15:0] count_o,
    output logic toggle_o,
    output logic expired_o
);
    // ------------------------------------------------------------------
    // Timer: counts down on instruction strobes, loads 256 on wakeup.
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            count_o <= 16'h0000;
        end else if (load_i) begin
            count_o <= PSS_WAKE_LOAD;
        end else if (tick_i) begin
            count_o <= count_o - 16'h0001;
        end
    end

    // Thirteenth bit changes on this strobe, every 4096 cycles.
    assign toggle_o = tick_i && !load_i && (count_o[11:0] == 12'h000);
    // Settle count reaches its end on the strobe that leaves it at zero.
    assign expired_o = tick_i && !load_i && (count_o == 16'h0001);
endmodule
`default_nettype wire

//--- logic/pss_sequencer.sv
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------
// What this block does
// - Halt bit write stops clocks and timers.
// - Idle bit write keeps oscillator, idle timer.
// - Low power keeps RAM, registers, pins, timers.
// - Halt exits on port wakeup or reset.
// - Halt wakeup loads 256, gates clocks after.
// - Instruction clock is oscillator over ten.
// - Halt-disable option ignores halt writes.
// - Idle exits on reset, wakeup, bit-12 toggle.
// - Each bit-12 toggle sets pending flag.
// - Tick interrupt needs enable; pending still works.
// - Enabled idle exit services tick interrupt first.
// - Disabled idle exit resumes next instruction.
// - Port M bit 7 clear disables bus wakeup.
// - Reference on while any comparator is on.
// - Pending bit 5, enable bit 4, global enable.
// - Bit-12 underflow clears idle bit, ends idle.
// ----------------------------------------------------------------------
module pss_sequencer
    import pss_pkg::*;
#(
    parameter bit HALT_DISABLE = 1'b0
)
(
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // AXI4-Lite slave.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Wakeup pins of ports L and M and the bus wakeup comparator.
    input wire logic [7:0] port_l_wake_i,
    input wire logic [6:0] port_m_wake_i,
    input wire logic can_wake_i,
    // Clock gating, comparator and reference controls, and interrupt outputs.
    output logic core_clk_en_o,
    output logic osc_en_o,
    output logic idle_timer_en_o,
    output logic can_main_comp_en_o,
    output logic can_wake_comp_en_o,
    output logic can_vref_en_o,
    output logic can_vref_oe_n_o,
    output logic tick_irq_o,
    output logic irq_o
);
    // ------------------------------------------------------------------
    // State and registers.
    // ------------------------------------------------------------------
    pss_state_t state; // Power state.
    logic [7:0] port_g; // Port G data, holds halt and idle flags.
    logic [7:0] int_control_reg; // Pending, enable, global enable.
    logic [7:0] can_bus_control_reg; // Receive comparator enables.
    logic [7:0] portm_wakeup_enable_reg; // Port M and bus wakeup enables.
    logic [7:0] portl_wakeup_enable_reg; // Port L wakeup enables.
    logic [2:0] irq_sts; // Sticky event bits.
    logic [2:0] irq_msk; // Event mask, one enables.
    logic [15:0] idle_timer; // Timer value for status reads.
    logic tick, toggle, expired, settle_load;
    logic [15:0] wake_s1, wake_s2; // Two-stage pin synchronisers.
    logic [15:0] wake_prev; // Previous synchronised level.
    logic wake_evt; // Rising edge on an enabled source.
    pss_evt_t evt;

    // ------------------------------------------------------------------
    // Wakeup pin synchronisers; only stage two is looked at.
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wake_s1 <= 16'h0000;
            wake_s2 <= 16'h0000;
            wake_prev <= 16'h0000;
        end else begin
            wake_s1 <= {can_wake_i, port_m_wake_i, port_l_wake_i};
            wake_s2 <= wake_s1;
            wake_prev <= wake_s2;
        end
    end

    // Enables: bus wakeup rides on port M bit 7.
    logic [15:0] wake_en;
    assign wake_en = {portm_wakeup_enable_reg[PSS_CANWK_BIT],
                      portm_wakeup_enable_reg[6:0],
                      portl_wakeup_enable_reg};
    logic [15:0] wake_rise;
    assign wake_rise = wake_s2 & ~wake_prev & wake_en;
    assign wake_evt = |wake_rise;

    // ------------------------------------------------------------------
    // Instruction strobe and idle timer.
    // ------------------------------------------------------------------
    // Halt stops the oscillator, so the divider phase clears and the timer holds.
    assign osc_en_o = (state != PSS_HALT);
    assign settle_load = (state == PSS_HALT) && wake_evt;

    pss_divider u_div (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .run_i(osc_en_o || settle_load),
        .tick_o(tick)
    );

    pss_idle_timer u_tmr (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .tick_i(tick && state != PSS_HALT),
        .load_i(settle_load),
        .count_o(idle_timer),
        .toggle_o(toggle),
        .expired_o(expired)
    );

    // Oscillator and timer keep going in idle; core clocks gate off.
    assign idle_timer_en_o = osc_en_o;
    assign core_clk_en_o = (state == PSS_RUN);

    // ------------------------------------------------------------------
    // AXI4-Lite write path: address and data taken in either order.
    // ------------------------------------------------------------------
    logic aw_held, w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign do_write = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    // Every address answers OKAY; unmapped writes are dropped.
    assign s_axi_bresp = 2'b00;

    // Write of one register byte with lane 0 enabled.
    function automatic logic hit(input logic [7:0] off);
        hit = do_write && (aw_addr == off) && w_strb[0];
    endfunction

    // ------------------------------------------------------------------
    // Power state machine.
    // ------------------------------------------------------------------
    logic halt_req, idle_req;
    assign halt_req = hit(PSS_OFF_PORTG) && w_data[PSS_HALT_BIT]
                      && !HALT_DISABLE;
    assign idle_req = hit(PSS_OFF_PORTG) && w_data[PSS_IDLE_BIT];

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state <= PSS_RUN; // Reset pin also ends halt and idle.
        end else begin
            case (state)
                PSS_RUN: begin
                    if (halt_req) begin
                        state <= PSS_HALT;
                    end else if (idle_req) begin
                        state <= PSS_IDLE;
                    end
                end
                PSS_IDLE: begin
                    if (toggle || wake_evt) begin
                        state <= PSS_RUN;
                    end
                end
                PSS_HALT: begin
                    if (wake_evt) begin
                        state <= PSS_SETTLE;
                    end
                end
                PSS_SETTLE: begin
                    if (expired) begin
                        state <= PSS_RUN;
                    end
                end
                default: begin
                    state <= PSS_RUN;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Port G data byte; hardware clears the flags on exit.
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            port_g <= PSS_RST_BYTE;
        end else begin
            if (hit(PSS_OFF_PORTG)) begin
                port_g <= w_data[7:0];
                if (HALT_DISABLE) begin
                    port_g[PSS_HALT_BIT] <= 1'b0;
                end
            end
            if (toggle) begin
                port_g[PSS_IDLE_BIT] <= 1'b0;
            end
            if (state == PSS_IDLE && wake_evt) begin
                port_g[PSS_IDLE_BIT] <= 1'b0;
            end
            if (state == PSS_SETTLE && expired) begin
                port_g[PSS_HALT_BIT] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Interrupt control: the toggle set wins over a clearing write.
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            int_control_reg <= PSS_RST_BYTE;
        end else begin
            if (hit(PSS_OFF_INTCTL)) begin
                int_control_reg <= w_data[7:0];
            end
            if (toggle) begin
                int_control_reg[PSS_PEND_BIT] <= 1'b1;
            end
        end
    end

    // Pending flag runs regardless of the enable.
    // With the enable set, the core takes the service routine before
    // resuming after the enter-idle write; otherwise it just resumes.
    assign tick_irq_o = int_control_reg[PSS_PEND_BIT]
                        && int_control_reg[PSS_TEN_BIT]
                        && int_control_reg[PSS_GIE_BIT];

    // ------------------------------------------------------------------
    // Bus comparator enables and wakeup enable registers.
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            can_bus_control_reg <= PSS_RST_BYTE;
            portm_wakeup_enable_reg <= PSS_RST_BYTE;
            portl_wakeup_enable_reg <= PSS_RST_BYTE;
        end else begin
            if (hit(PSS_OFF_CANBUS)) begin
                can_bus_control_reg <= w_data[7:0];
            end
            if (hit(PSS_OFF_PORTM_WAKEUP_ENABLE_REG)) begin
                portm_wakeup_enable_reg <= w_data[7:0];
            end
            if (hit(PSS_OFF_LWKEN)) begin
                portl_wakeup_enable_reg <= w_data[7:0];
            end
        end
    end

    // Main comparator off only when both enables are cleared.
    assign can_main_comp_en_o = can_bus_control_reg[PSS_RXLO_BIT]
                                || can_bus_control_reg[PSS_RXHI_BIT];
    assign can_wake_comp_en_o = portm_wakeup_enable_reg[PSS_CANWK_BIT];
    // Reference follows either comparator; pin floats when off.
    assign can_vref_en_o = can_main_comp_en_o || can_wake_comp_en_o;
    assign can_vref_oe_n_o = !can_vref_en_o;

    // ------------------------------------------------------------------
    // Sticky interrupt status, write one to clear; set beats clear.
    // ------------------------------------------------------------------
    assign evt.tick = toggle;
    assign evt.idle_exit = (state == PSS_IDLE) && (toggle || wake_evt);
    assign evt.wake_done = (state == PSS_SETTLE) && expired;

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_sts <= 3'h0;
            irq_msk <= 3'h0;
        end else begin
            if (hit(PSS_OFF_IRQ_MSK)) begin
                irq_msk <= w_data[2:0];
            end
            if (hit(PSS_OFF_IRQ_STS)) begin
                irq_sts <= (irq_sts & ~w_data[2:0]) | evt;
            end else begin
                irq_sts <= irq_sts | evt;
            end
        end
    end
    assign irq_o = |(irq_sts & irq_msk);

    // ------------------------------------------------------------------
    // AXI4-Lite read path: one cycle to answer, rdata from a register.
    // ------------------------------------------------------------------
    assign s_axi_arready = !s_axi_rvalid;
    assign s_axi_rresp = 2'b00;

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            case (s_axi_araddr)
                PSS_OFF_PORTG: s_axi_rdata <= {24'h0, port_g};
                PSS_OFF_INTCTL: s_axi_rdata <= {24'h0, int_control_reg};
                PSS_OFF_CANBUS: s_axi_rdata <= {24'h0, can_bus_control_reg};
                PSS_OFF_PORTM_WAKEUP_ENABLE_REG: s_axi_rdata <= {24'h0, portm_wakeup_enable_reg};
                PSS_OFF_LWKEN: s_axi_rdata <= {24'h0, portl_wakeup_enable_reg};
                PSS_OFF_STATUS: s_axi_rdata <= {14'h0, state, idle_timer};
                PSS_OFF_IRQ_STS: s_axi_rdata <= {29'h0, irq_sts};
                PSS_OFF_IRQ_MSK: s_axi_rdata <= {29'h0, irq_msk};
                default: s_axi_rdata <= 32'h0000_0000;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------
    property p_halt_enter;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (state == PSS_RUN && halt_req) |=> (state == PSS_HALT && !osc_en_o);
    endproperty
    a_halt_enter: assert property (p_halt_enter)
        else $error("halt write did not stop the oscillator");

    property p_idle_enter;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (state == PSS_RUN && !halt_req && idle_req) |=>
            (state == PSS_IDLE && osc_en_o && !core_clk_en_o);
    endproperty
    a_idle_enter: assert property (p_idle_enter)
        else $error("idle write did not gate the core only");

    property p_halt_wake;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (state == PSS_HALT && wake_evt) |=>
            (state == PSS_SETTLE && idle_timer == PSS_WAKE_LOAD);
    endproperty
    a_halt_wake: assert property (p_halt_wake)
        else $error("halt wakeup did not load the settle count");

    property p_settle_len;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        $rose(state == PSS_SETTLE) |-> !core_clk_en_o [*8];
    endproperty
    a_settle_len: assert property (p_settle_len)
        else $error("core clocks released during settle");

    property p_div;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        tick |=> !tick [*8] ##1 !tick;
    endproperty
    a_div: assert property (p_div)
        else $error("instruction strobe spacing not ten");

    // A halt write must take effect exactly when the option allows it.
    property p_halt_off;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        ((state == PSS_RUN && do_write && aw_addr == PSS_OFF_PORTG
          && w_strb[0] && w_data[PSS_HALT_BIT]) |=>
            ((state == PSS_HALT) == !HALT_DISABLE))
        and (!HALT_DISABLE || state != PSS_HALT);
    endproperty
    a_halt_off: assert property (p_halt_off)
        else $error("halt entered with halt disabled");

    property p_idle_exit;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (state == PSS_IDLE && toggle) |=>
            (state == PSS_RUN && !port_g[PSS_IDLE_BIT]
             && int_control_reg[PSS_PEND_BIT]);
    endproperty
    a_idle_exit: assert property (p_idle_exit)
        else $error("timer toggle did not end idle");

    property p_irq_gate;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        !int_control_reg[PSS_TEN_BIT] |-> !tick_irq_o;
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("tick interrupt without enable");

    property p_vref;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        can_vref_en_o == (can_bus_control_reg[PSS_RXLO_BIT]
            || can_bus_control_reg[PSS_RXHI_BIT]
            || portm_wakeup_enable_reg[PSS_CANWK_BIT])
        && can_vref_oe_n_o == !can_vref_en_o;
    endproperty
    a_vref: assert property (p_vref)
        else $error("reference not following comparators");

    property p_halt_clear;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (state == PSS_SETTLE && expired) |=> !port_g[PSS_HALT_BIT];
    endproperty
    a_halt_clear: assert property (p_halt_clear)
        else $error("halt flag left set after wakeup");

    c_halt_cycle: cover property (@(posedge clk_sys_i)
        state == PSS_SETTLE ##1 state == PSS_RUN);
    c_idle_wake: cover property (@(posedge clk_sys_i)
        state == PSS_IDLE && wake_evt);
    c_tick_irq: cover property (@(posedge clk_sys_i) $rose(tick_irq_o));
endmodule
`default_nettype wire

//--- verification/pss_wake_pins.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------
// Wakeup pins model: every pin rests low between events.
// ----------------------------------------------------------------------
module pss_wake_pins (
    input wire logic clk_sys_i,
    output logic [7:0] port_l_o,
    output logic [6:0] port_m_o,
    output logic can_o
);
    // One rising edge; held four cycles so the two-stage sync sees it.
    task automatic pulse(input int idx);
        @(posedge clk_sys_i);
        if (idx < 8) port_l_o[idx] <= 1'b1;
        else if (idx < 15) port_m_o[idx - 8] <= 1'b1;
        else can_o <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        port_l_o <= 8'h00;
        port_m_o <= 7'h00;
        can_o <= 1'b0;
    endtask
    initial begin
        port_l_o = 8'h00;
        port_m_o = 7'h00;
        can_o = 1'b0;
    end
endmodule
`default_nettype wire

//--- verification/power_save_sequencer_test.sv
`timescale 1ns/100ps
`default_nettype none
module power_save_sequencer_test
    import pss_pkg::*;
;
    logic clk_sys_i, resetn_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, can_wake_i;
    logic core_clk_en_o, osc_en_o, idle_timer_en_o, can_main_comp_en_o;
    logic can_wake_comp_en_o, can_vref_en_o, can_vref_oe_n_o, tick_irq_o;
    logic irq_o;
    logic [7:0] s_axi_awaddr, s_axi_araddr, port_l_wake_i;
    logic [6:0] port_m_wake_i;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int num_errors = 0;
    int checked = 0;
    pss_sequencer dut (.clk_sys_i, .resetn_i, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port_l_wake_i,
        .port_m_wake_i, .can_wake_i, .core_clk_en_o, .osc_en_o,
        .idle_timer_en_o, .can_main_comp_en_o, .can_wake_comp_en_o,
        .can_vref_en_o, .can_vref_oe_n_o, .tick_irq_o, .irq_o);
    pss_wake_pins pins (.clk_sys_i, .port_l_o(port_l_wake_i),
        .port_m_o(port_m_wake_i), .can_o(can_wake_i));
    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    // Write: address and data offered together, each dropped when taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
    endtask
    task automatic rdr(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
    endtask
    // Bounded wait for the core clocks to come back.
    task automatic wait_run(input int n);
        for (int i = 0; i < n && core_clk_en_o !== 1'b1; i++)
            @(posedge clk_sys_i);
    endtask
    task automatic t_can;
        wr(PSS_OFF_CANBUS, 32'h3);
        chk(can_main_comp_en_o, 1);
        chk({can_wake_comp_en_o, can_vref_oe_n_o}, 0);
        wr(PSS_OFF_PORTM_WAKEUP_ENABLE_REG, 32'h80);
        wr(PSS_OFF_CANBUS, 32'h0);
        chk(can_main_comp_en_o, 0);
        chk({can_wake_comp_en_o, can_vref_en_o}, 3);
        wr(PSS_OFF_PORTM_WAKEUP_ENABLE_REG, 32'h0);
        chk({can_wake_comp_en_o, can_vref_en_o, can_vref_oe_n_o}, 1);
        rdr(8'h20);
        chk(rd, 0);
    endtask
    task automatic t_halt;
        wr(PSS_OFF_LWKEN, 32'h1);
        wr(PSS_OFF_PORTG, 32'h80);
        repeat (2) @(posedge clk_sys_i);
        chk({core_clk_en_o, osc_en_o, idle_timer_en_o}, 0);
        pins.pulse(0);
        chk({core_clk_en_o, osc_en_o}, 1);
        repeat (2000) @(posedge clk_sys_i);
        chk(core_clk_en_o, 0);
        wait_run(1000);
        chk(core_clk_en_o, 1);
        rdr(PSS_OFF_PORTG);
        chk(rd[7], 0);
    endtask
    task automatic t_idle_can;
        // Let the toggle that follows the settle count pass first, so
        // that only the bus wakeup can end this idle spell.
        repeat (20) @(posedge clk_sys_i);
        wr(PSS_OFF_PORTM_WAKEUP_ENABLE_REG, 32'h80);
        wr(PSS_OFF_PORTG, 32'h40);
        repeat (2) @(posedge clk_sys_i);
        chk({core_clk_en_o, osc_en_o, idle_timer_en_o}, 3);
        pins.pulse(15);
        wait_run(20);
        chk(core_clk_en_o, 1);
        wr(PSS_OFF_PORTM_WAKEUP_ENABLE_REG, 32'h0);
    endtask
    task automatic t_idle_tick;
        // Drop events left by earlier toggles so the flags start clean.
        wr(PSS_OFF_IRQ_STS, 32'h7);
        wr(PSS_OFF_IRQ_MSK, 32'h1);
        wr(PSS_OFF_INTCTL, 32'h11);
        chk({tick_irq_o, irq_o}, 0);
        wr(PSS_OFF_PORTG, 32'h40);
        repeat (2) @(posedge clk_sys_i);
        wait_run(42000);
        chk(core_clk_en_o, 1);
        rdr(PSS_OFF_PORTG);
        chk(rd[6], 0);
        chk({tick_irq_o, irq_o}, 3);
        wr(PSS_OFF_INTCTL, 32'h21);
        chk(tick_irq_o, 0);
        rdr(PSS_OFF_INTCTL);
        chk(rd[5], 1);
        wr(PSS_OFF_IRQ_STS, 32'h1);
        chk(irq_o, 0);
    endtask
    task automatic give_verdict;
        $display("Errors %0d, checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        // Response readies stay high throughout the run.
        {s_axi_awvalid, s_axi_wvalid} = 2'h0;
        {s_axi_bready, s_axi_rready} = 2'h3;
        {s_axi_arvalid, resetn_i} = 2'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hF;
        repeat (12) @(posedge clk_sys_i);
        chk({core_clk_en_o, osc_en_o, can_vref_oe_n_o, irq_o}, 14);
        resetn_i <= 1'b1;
        t_can();
        t_halt();
        t_idle_can();
        t_idle_tick();
        give_verdict();
    end
    // Longest path is one bit-12 toggle period of the idle timer plus the settle count.
    initial begin
        repeat (90000) @(posedge clk_sys_i);
        num_errors++;
        give_verdict();
    end
endmodule
`default_nettype wire
